// File: common/nor_host_cfg.svh
// Timing constants and fixed command values for the NOR flash host sequencer
// How it works
// - Erase resume continues; 30 us before next suspend
// - No protect commands while any suspend holds
// - Program resume continues; 30 us before next suspend
// - Wait 200 ns after reset before reading
// - Write needs select low, write low, output-enable high
// - OTP lock writes zero bit0, wait over 100 us
`ifndef NOR_HOST_CFG_SVH
`define NOR_HOST_CFG_SVH

// ----------------------------------------------------------------------
// Clock and documented times
// ----------------------------------------------------------------------
`define CLK_PERIOD_PS        8000
`define RESUME_GAP_NS        30000
`define ERASE_SUSP_MAX_NS    20000
`define PROG_SUSP_MAX_NS     10000
`define RESET_WAKE_NS        200
`define OTP_LOCK_NS          100000

// Least times round up to whole cycles
`define NS_TO_CYC_UP(ns)     ((((ns) * 1000) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

// ----------------------------------------------------------------------
// Query entry cycle and OTP lock bit
// ----------------------------------------------------------------------
`define QUERY_CMD_DATA       16'h0098
`define QUERY_CMD_ADDR       23'h000055
`define OTP_LOCK_BIT         0

`endif

// File: common/nor_host_pkg.sv
// Types shared by the NOR flash host sequencer
package nor_host_pkg;

    // Operations that the user side may request
    typedef enum logic [3:0] {
        op_read          = 4'h0,
        op_write         = 4'h1,
        op_erase_suspend = 4'h2,
        op_erase_resume  = 4'h3,
        op_prog_suspend  = 4'h4,
        op_prog_resume   = 4'h5,
        op_sw_reset      = 4'h6,
        op_hw_reset      = 4'h7,
        op_query_entry   = 4'h8,
        op_otp_lock      = 4'h9,
        op_protect       = 4'ha
    } op_t;

    typedef struct packed {
        op_t         op;
        logic [22:0] addr;
        logic [15:0] data;
    } cmd_t;

    typedef struct packed {
        op_t         op;
        logic        err;
        logic [15:0] data;
    } rsp_t;

    // Flash pin drive; dq_oe_n low while the host drives the data bus
    typedef struct packed {
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic        reset_n;
        logic        protect_accel_pin_n;
        logic [22:0] addr;
        logic [15:0] dq_out;
        logic        dq_oe_n;
    } flash_out_t;

endpackage

// File: tb/nor_flash_model.sv
// Behavioural NOR flash device as the host sequencer sees it at its pins
`timescale 1ns/1ps

module nor_flash_model
    import nor_host_pkg::*;
#(
    parameter int          ACC_NS   = 70,
    parameter logic [15:0] RST_CODE = 16'h0005
) (
    // Pins from the host
    input  wire flash_out_t  flash,
    // Data bus back to the host
    output wire logic [15:0] dq
);
    // ------------------------------------------------------------------
    // Array, query state and wake-up
    // ------------------------------------------------------------------
    logic [15:0] mem [logic [22:0]];
    logic        query_reg = 1'b0;
    logic        awake     = 1'b0;
    logic [15:0] last      = 16'h0000;
    logic [15:0] rd        = 16'h0000;
    wire         drive     = !flash.ce_n && !flash.oe_n && awake;

    // Pin low aborts everything; data stays invalid 200 ns after release
    always @(flash.reset_n) begin
        awake     = 1'b0;
        query_reg = 1'b0;
        if (flash.reset_n === 1'b1) #200 awake = 1'b1;
    end

    // Only select low, write low and output enable high makes a write
    always @(posedge flash.we_n) begin
        if (!flash.ce_n && flash.oe_n && awake) begin
            if (flash.dq_out == 16'h0098 && flash.addr == 23'h000055) query_reg = 1'b1;
            else if (flash.dq_out == RST_CODE) query_reg = 1'b0;
            else if (flash.protect_accel_pin_n || flash.addr[22:16] != 7'h7f) begin
                mem[flash.addr] = flash.dq_out;
            end
        end
    end

    // Lookup at strobe fall; unwritten words read as erased
    always @(negedge flash.oe_n) begin
        rd = query_reg ? 16'h0051 : (mem.exists(flash.addr) ? mem[flash.addr] : 16'hffff);
    end

    // Released bus shows the inverse of the last word, never a stale match
    always @(negedge drive) last = rd;
    assign #(ACC_NS) dq = drive ? rd : ~last;
endmodule

// File: tb/nor_host_ctrl_tb_top.sv
// Self-checking bench for the NOR flash host sequencer
`timescale 1ns/1ps

module nor_host_ctrl_tb_top
    import nor_host_pkg::*;
;
    // ------------------------------------------------------------------
    // Stimulus, design and device model
    // ------------------------------------------------------------------
    logic        ref_clk = 1'b0, arst_n = 1'b0, cmd_valid = 1'b0;
    logic        boot_protect_n = 1'b1, supply_low = 1'b0;
    cmd_t        cmd = '0;
    logic        cmd_ready, rsp_valid;
    rsp_t        rsp;
    flash_out_t  flash;
    logic [15:0] dq;
    int          n_fail = 0, samples_checked = 0, cyc;
    rsp_t        exp_q[$];
    bit          dat_q[$];
    logic [15:0] wd [4];
    logic [22:0] wa [4];

    nor_host_ctrl #(.RESET_PULSE_CYC(8), .OTP_LOCK_WAIT_CYC(20)) u_nor_host_ctrl (
        .ref_clk(ref_clk), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd(cmd),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp),
        .boot_protect_n(boot_protect_n), .supply_low(supply_low), .flash(flash), .dq_in(dq));
    nor_flash_model u_nor_flash_model (.flash(flash), .dq(dq));

    // 125 MHz clock
    always #4 ref_clk = ~ref_clk;

    task automatic chk(input bit ok, input string m);
        samples_checked++;
        if (!ok) begin
            n_fail++;
            $display("Error at %0t: %s", $time, m);
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // One request: note the answer, hold valid until taken, then wait for it.
    // A suspend may stall behind the resume guard, so its take is seen as ready falling.
    task automatic do_op(input op_t o, input logic [22:0] a, input logic [15:0] d,
                         input logic e, input logic [15:0] xd, output int n);
        logic rdy;
        exp_q.push_back('{op: o, err: e, data: xd});
        dat_q.push_back(o == op_read);
        // Let the previous answer's edge pass, so valid never falls and rises in one step
        @(posedge ref_clk);
        #1 n = 0;
        cmd = '{op: o, addr: a, data: d};
        cmd_valid = 1'b1;
        do begin
            rdy = cmd_ready;
            @(posedge ref_clk);
            #1 n++;
        end while (!(rdy && (!(o inside {op_erase_suspend, op_prog_suspend}) || !cmd_ready))
                   && n < 9000);
        cmd_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 9000) begin
            @(posedge ref_clk);
            #1 n++;
        end
        // A request that never completes is a mismatch, not a silent skip
        if (n >= 9000) chk(1'b0, "request stalled");
    endtask

    // ------------------------------------------------------------------
    // Answer watcher: oldest note against each answer
    // ------------------------------------------------------------------
    always @(negedge ref_clk) begin
        if (rsp_valid === 1'b1) begin
            if (exp_q.size() == 0) chk(1'b0, "answer without request");
            else begin
                chk(rsp.op === exp_q[0].op && rsp.err === exp_q[0].err
                    && (!dat_q[0] || rsp.data === exp_q[0].data), "answer differs");
                void'(exp_q.pop_front());
                void'(dat_q.pop_front());
            end
        end
    end

    // Tests take about 8000 cycles; cut off far beyond that
    initial begin
        #400000;
        chk(1'b0, "timeout");
        close_out();
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(32'h3799));
        exp_q.push_back('{op: op_hw_reset, err: 1'b0, data: 16'h0000});
        dat_q.push_back(1'b0);
        repeat (6) @(posedge ref_clk);
        chk(flash.reset_n === 1'b0 && flash.ce_n === 1'b1, "pins in reset");
        #1 arst_n = 1'b1;
        for (int i = 0; i < 4; i++) begin
            wa[i] = {13'h0004, 2'(i), 8'($urandom)};
            wd[i] = {1'b1, 15'($urandom)};
            do_op(op_write, wa[i], wd[i], 1'b0, 16'h0000, cyc);
        end
        for (int i = 0; i < 4; i++) do_op(op_read, wa[i], 16'h0000, 1'b0, wd[i], cyc);
        $display("write and read done");
        do_op(op_query_entry, 23'h0, 16'h0000, 1'b0, 16'h0000, cyc);
        do_op(op_read, wa[0], 16'h0000, 1'b0, 16'h0051, cyc);
        do_op(op_sw_reset, 23'h0, 16'h0000, 1'b0, 16'h0000, cyc);
        do_op(op_read, wa[0], 16'h0000, 1'b0, wd[0], cyc);
        do_op(op_query_entry, 23'h0, 16'h0000, 1'b0, 16'h0000, cyc);
        do_op(op_hw_reset, 23'h0, 16'h0000, 1'b0, 16'h0000, cyc);
        do_op(op_read, wa[1], 16'h0000, 1'b0, wd[1], cyc);
        $display("query and resets done");
        boot_protect_n = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 chk(flash.protect_accel_pin_n === 1'b0, "protect pin high");
        do_op(op_write, 23'h7f0010, 16'h8123, 1'b0, 16'h0000, cyc);
        do_op(op_read, 23'h7f0010, 16'h0000, 1'b0, 16'hffff, cyc);
        boot_protect_n = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1 chk(flash.protect_accel_pin_n === 1'b1, "protect pin low");
        do_op(op_write, 23'h7f0010, 16'h8123, 1'b0, 16'h0000, cyc);
        do_op(op_read, 23'h7f0010, 16'h0000, 1'b0, 16'h8123, cyc);
        $display("boot protect done");
        do_op(op_erase_suspend, 23'h0, 16'h0000, 1'b0, 16'h0000, cyc);
        chk(cyc >= 2509, "erase suspend answered early");
        do_op(op_protect, 23'h0, 16'h0000, 1'b1, 16'h0000, cyc);
        do_op(op_otp_lock, 23'h0, 16'h0000, 1'b1, 16'h0000, cyc);
        do_op(op_read, wa[2], 16'h0000, 1'b0, wd[2], cyc);
        do_op(op_erase_resume, 23'h0, 16'h0000, 1'b0, 16'h0000, cyc);
        do_op(op_prog_suspend, 23'h0, 16'h0000, 1'b0, 16'h0000, cyc);
        chk(cyc >= 4990, "suspend inside resume guard");
        do_op(op_prog_resume, 23'h0, 16'h0000, 1'b0, 16'h0000, cyc);
        $display("suspend and resume done");
        supply_low = 1'b1;
        repeat (4) @(posedge ref_clk);
        #1 do_op(op_write, wa[3], 16'h8000, 1'b1, 16'h0000, cyc);
        do_op(op_read, wa[3], 16'h0000, 1'b0, wd[3], cyc);
        supply_low = 1'b0;
        repeat (4) @(posedge ref_clk);
        #1 do_op(op_otp_lock, 23'h000100, 16'hffff, 1'b0, 16'h0000, cyc);
        chk(cyc >= 20, "lock wait short");
        do_op(op_read, 23'h000100, 16'h0000, 1'b0, 16'hfffe, cyc);
        $display("lockout and otp lock done");
        @(negedge ref_clk);
        #1 chk(exp_q.size() == 0, "answers missing");
        close_out();
    end
endmodule

// File: verilog/nor_host_ctrl.sv
// Host-side sequencer that drives an asynchronous page NOR flash over its pins
`timescale 1ns/1ps
`include "nor_host_cfg.svh"

module nor_host_ctrl
    import nor_host_pkg::*;
#(
    parameter int CMD_ERASE_SUSPEND = 16'h0001,
    parameter int CMD_ERASE_RESUME  = 16'h0002,
    parameter int CMD_PROG_SUSPEND  = 16'h0003,
    parameter int CMD_PROG_RESUME   = 16'h0004,
    parameter int CMD_SW_RESET      = 16'h0005,
    parameter int WE_PULSE_CYC      = 6,
    parameter int READ_STROBE_CYC   = 12,
    parameter int RESET_PULSE_CYC   = 64,
    parameter int OTP_LOCK_WAIT_CYC = `NS_TO_CYC_UP(`OTP_LOCK_NS) + 1
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    // User request and answer
    input  wire logic        cmd_valid,
    input  wire cmd_t        cmd,
    output logic             cmd_ready,
    output logic             rsp_valid,
    output rsp_t             rsp,
    // System levels
    input  wire logic        boot_protect_n,
    input  wire logic        supply_low,
    // Flash pins
    output flash_out_t       flash,
    input  wire logic [15:0] dq_in
);

    localparam int RESUME_GAP_CYC = `NS_TO_CYC_UP(`RESUME_GAP_NS);
    localparam int ERASE_SUSP_CYC = `NS_TO_CYC_UP(`ERASE_SUSP_MAX_NS);
    localparam int PROG_SUSP_CYC  = `NS_TO_CYC_UP(`PROG_SUSP_MAX_NS);
    localparam int WAKE_CYC       = `NS_TO_CYC_UP(`RESET_WAKE_NS);

    typedef enum logic [2:0] {
        st_idle   = 3'b000,
        st_setup  = 3'b001,
        st_strobe = 3'b011,
        st_finish = 3'b010,
        st_wait   = 3'b110,
        st_rst    = 3'b111
    } state_t;

    // ------------------------------------------------------------------
    // Reset release and input synchronisers
    // ------------------------------------------------------------------
    logic        rst_meta_reg;
    logic        rst_n;
    logic [15:0] dq_meta_reg;
    logic [15:0] dq_sync_reg;
    logic        low_meta_reg;
    logic        low_sync_reg;

    // Reset enters asynchronously but is released on the clock
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    // Data bus and supply monitor are asynchronous to us
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dq_meta_reg  <= 16'h0000;
            dq_sync_reg  <= 16'h0000;
            low_meta_reg <= 1'b1;
            low_sync_reg <= 1'b1;
        end else begin
            dq_meta_reg  <= dq_in;
            dq_sync_reg  <= dq_meta_reg;
            low_meta_reg <= supply_low;
            low_sync_reg <= low_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------------
    state_t      state_reg;
    op_t         op_reg;
    logic [15:0] cnt_reg;
    logic [11:0] guard_reg;
    logic        esusp_reg;
    logic        psusp_reg;
    flash_out_t  flash_reg;
    logic        refuse;
    logic        take;

    function automatic logic is_suspend(input op_t op);
        return (op == op_erase_suspend) || (op == op_prog_suspend);
    endfunction

    function automatic logic is_bus_write(input op_t op);
        return (op != op_read) && (op != op_hw_reset);
    endfunction

    // A suspend is held back, not refused, until the resume gap runs out
    assign take = cmd_valid && cmd_ready &&
                  !(is_suspend(cmd.op) && (guard_reg != 12'h000));

    // Refused requests answer with an error and never reach the pins
    always_comb begin
        refuse = 1'b0;
        if ((cmd.op == op_protect) && (esusp_reg || psusp_reg))
            refuse = 1'b1;
        if ((cmd.op == op_otp_lock) && (esusp_reg || psusp_reg))
            refuse = 1'b1;
        if (is_bus_write(cmd.op) && low_sync_reg)
            refuse = 1'b1;
    end

    // ------------------------------------------------------------------
    // Bus cycle sequencer
    // ------------------------------------------------------------------
    // Every bus cycle is select, strobe, release; long waits follow in st_wait
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= st_rst;
            op_reg    <= op_hw_reset;
            cnt_reg   <= 16'(RESET_PULSE_CYC);
            cmd_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp       <= '{op: op_hw_reset, err: 1'b0, data: 16'h0000};
            flash_reg <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_n: 1'b0,
                           protect_accel_pin_n: 1'b0, addr: 23'h000000,
                           dq_out: 16'h0000, dq_oe_n: 1'b1};
        end else begin
            rsp_valid <= 1'b0;
            flash_reg.protect_accel_pin_n <= boot_protect_n;
            unique case (state_reg)
                st_idle: begin
                    if (take && (cmd.op == op_hw_reset)) begin
                        // Pulse low aborts the device and floats its outputs
                        cmd_ready         <= 1'b0;
                        op_reg            <= op_hw_reset;
                        cnt_reg           <= 16'(RESET_PULSE_CYC);
                        flash_reg.reset_n <= 1'b0;
                        state_reg         <= st_rst;
                    end else if (take && refuse) begin
                        rsp_valid <= 1'b1;
                        rsp       <= '{op: cmd.op, err: 1'b1, data: 16'h0000};
                    end else if (take) begin
                        cmd_ready      <= 1'b0;
                        op_reg         <= cmd.op;
                        flash_reg.ce_n <= 1'b0;
                        flash_reg.addr <= cmd.addr;
                        flash_reg.dq_oe_n <= !is_bus_write(cmd.op);
                        unique case (cmd.op)
                            op_erase_suspend: flash_reg.dq_out <= 16'(CMD_ERASE_SUSPEND);
                            op_erase_resume:  flash_reg.dq_out <= 16'(CMD_ERASE_RESUME);
                            op_prog_suspend:  flash_reg.dq_out <= 16'(CMD_PROG_SUSPEND);
                            op_prog_resume:   flash_reg.dq_out <= 16'(CMD_PROG_RESUME);
                            op_sw_reset:      flash_reg.dq_out <= 16'(CMD_SW_RESET);
                            op_query_entry: begin
                                flash_reg.addr   <= `QUERY_CMD_ADDR;
                                flash_reg.dq_out <= `QUERY_CMD_DATA;
                            end
                            op_otp_lock: begin
                                flash_reg.dq_out <= cmd.data;
                                flash_reg.dq_out[`OTP_LOCK_BIT] <= 1'b0;
                            end
                            default: flash_reg.dq_out <= cmd.data;
                        endcase
                        state_reg <= st_setup;
                    end
                end
                st_setup: begin
                    // Address and select settle one cycle before the strobe
                    if (is_bus_write(op_reg)) begin
                        flash_reg.we_n <= 1'b0;
                        cnt_reg        <= 16'(WE_PULSE_CYC);
                    end else begin
                        flash_reg.oe_n <= 1'b0;
                        cnt_reg        <= 16'(READ_STROBE_CYC);
                    end
                    state_reg <= st_strobe;
                end
                st_strobe: begin
                    cnt_reg <= cnt_reg - 16'h0001;
                    if (cnt_reg == 16'h0001) begin
                        // Read strobe covers access time plus two sync stages
                        flash_reg.we_n <= 1'b1;
                        flash_reg.oe_n <= 1'b1;
                        rsp.data       <= dq_sync_reg;
                        state_reg      <= st_finish;
                    end
                end
                st_finish: begin
                    flash_reg.ce_n    <= 1'b1;
                    flash_reg.dq_oe_n <= 1'b1;
                    rsp.op            <= op_reg;
                    rsp.err           <= 1'b0;
                    state_reg         <= st_wait;
                    // Worst-case latency is waited out; early suspend is not visible to us
                    unique case (op_reg)
                        op_erase_suspend: cnt_reg <= 16'(ERASE_SUSP_CYC);
                        op_prog_suspend:  cnt_reg <= 16'(PROG_SUSP_CYC);
                        op_otp_lock:      cnt_reg <= 16'(OTP_LOCK_WAIT_CYC);
                        default:          cnt_reg <= 16'h0001;
                    endcase
                end
                st_wait: begin
                    cnt_reg <= cnt_reg - 16'h0001;
                    if (cnt_reg == 16'h0001) begin
                        rsp_valid <= 1'b1;
                        rsp.op    <= op_reg;
                        rsp.err   <= 1'b0;
                        cmd_ready <= 1'b1;
                        state_reg <= st_idle;
                    end
                end
                st_rst: begin
                    cnt_reg <= cnt_reg - 16'h0001;
                    if (cnt_reg == 16'h0001) begin
                        flash_reg.reset_n <= 1'b1;
                        cnt_reg           <= 16'(WAKE_CYC);
                        state_reg         <= st_wait;
                    end
                end
                default: state_reg <= st_rst;
            endcase
        end
    end

    assign flash = flash_reg;

    // ------------------------------------------------------------------
    // Suspend tracking and resume spacing
    // ------------------------------------------------------------------
    // Mirrors the device mode; software reset keeps the suspend in force
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            esusp_reg <= 1'b0;
            psusp_reg <= 1'b0;
            guard_reg <= 12'h000;
        end else begin
            if (guard_reg != 12'h000)
                guard_reg <= guard_reg - 12'h001;
            if (state_reg == st_rst) begin
                esusp_reg <= 1'b0;
                psusp_reg <= 1'b0;
            end else if (state_reg == st_finish) begin
                unique case (op_reg)
                    op_erase_suspend: esusp_reg <= 1'b1;
                    op_prog_suspend:  psusp_reg <= 1'b1;
                    op_erase_resume: begin
                        esusp_reg <= 1'b0;
                        guard_reg <= 12'(RESUME_GAP_CYC);
                    end
                    op_prog_resume: begin
                        psusp_reg <= 1'b0;
                        guard_reg <= 12'(RESUME_GAP_CYC);
                    end
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions and helper counters
    // ------------------------------------------------------------------
    logic [7:0]  since_rst_reg;
    logic [15:0] since_otp_reg;
    logic [11:0] since_res_reg;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            since_rst_reg <= 8'h00;
            since_otp_reg <= 16'h0000;
            since_res_reg <= 12'hfff;
        end else begin
            since_rst_reg <= !flash_reg.reset_n ? 8'h00 :
                             (since_rst_reg == 8'hff) ? 8'hff : since_rst_reg + 8'h01;
            since_otp_reg <= (state_reg == st_finish && op_reg == op_otp_lock) ? 16'h0000 :
                             (since_otp_reg == 16'hffff) ? 16'hffff : since_otp_reg + 16'h0001;
            since_res_reg <= (state_reg == st_finish && (op_reg == op_erase_resume ||
                              op_reg == op_prog_resume)) ? 12'h000 :
                             (since_res_reg == 12'hfff) ? 12'hfff : since_res_reg + 12'h001;
        end
    end

    a_write_strobe_legal: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !flash.we_n |-> (!flash.ce_n && flash.oe_n && !flash.dq_oe_n))
        else $error("write strobe without select or with output enable");
    a_erase_suspend_gap: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_reg == st_setup && op_reg == op_erase_suspend) |-> since_res_reg >= RESUME_GAP_CYC)
        else $error("erase suspend too soon after resume");
    a_prog_suspend_gap: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_reg == st_setup && op_reg == op_prog_suspend) |-> since_res_reg >= RESUME_GAP_CYC)
        else $error("program suspend too soon after resume");
    a_protect_when_susp: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (take && cmd.op == op_protect && (esusp_reg || psusp_reg))
        |=> (rsp_valid && rsp.err && state_reg == st_idle) ##1 flash.we_n[*3])
        else $error("protect command reached the pins during suspend");
    a_reset_wake_time: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !flash.oe_n |-> since_rst_reg >= WAKE_CYC)
        else $error("read strobe within wake time after reset");
    a_otp_lock_wait: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (rsp_valid && rsp.op == op_otp_lock && !rsp.err) |-> since_otp_reg >= OTP_LOCK_WAIT_CYC)
        else $error("otp lock answered before its minimum time");
    a_otp_bit_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!flash.we_n && op_reg == op_otp_lock) |-> !flash.dq_out[`OTP_LOCK_BIT])
        else $error("otp lock written with bit zero set");
    a_otp_refused_susp: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (take && cmd.op == op_otp_lock && esusp_reg) |=> (rsp_valid && rsp.err))
        else $error("otp lock not refused during suspend");
    a_lockout_no_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (take && is_bus_write(cmd.op) && low_sync_reg) |=> state_reg == st_idle)
        else $error("bus write started during supply lockout");
    a_reset_pulse_width: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $fell(flash.reset_n) |-> !flash.reset_n[*8])
        else $error("reset pulse too short");

    c_erase_suspend_resume: cover property (@(posedge ref_clk) disable iff (!rst_n)
        rsp_valid && rsp.op == op_erase_resume);
    c_prog_in_erase_susp: cover property (@(posedge ref_clk) disable iff (!rst_n)
        rsp_valid && rsp.op == op_prog_suspend && esusp_reg);
    c_otp_locked: cover property (@(posedge ref_clk) disable iff (!rst_n)
        rsp_valid && rsp.op == op_otp_lock && !rsp.err);
    c_hw_reset_done: cover property (@(posedge ref_clk) disable iff (!rst_n)
        rsp_valid && rsp.op == op_hw_reset);

endmodule
